//--- shared/crs_pkg.sv
package crs_pkg;
  // Register offsets on the bus
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_HX = 8'h04;
  localparam logic [7:0] OFF_SP = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_CCR = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam int STAT_PEND_LSB = 8;
  // Reset values and vectors
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [7:0] SP_LOW_RST = 8'hFF;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_IRQ_TOP = 16'hFFFC;
  localparam logic [7:0] CCR_ONES = 8'h60;
  localparam logic [7:0] CCR_RST = 8'h68;
  // Flag positions
  localparam int CCR_V = 7;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;
  localparam logic [2:0] STACK_LAST = 3'h4;
  typedef enum logic [3:0] {
    OP_NOP, OP_FETCH, OP_JUMP, OP_ALU, OP_LDH, OP_LDX, OP_LDSP, OP_SPLOW,
    OP_PUSH, OP_PULL, OP_EA, OP_UNMASK, OP_SEI, OP_INTCHK, OP_IRQRET
  } crs_op_t;
  typedef enum logic [3:0] {
    FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_CMP, FN_AND, FN_ORA, FN_EOR,
    FN_LDA, FN_LSL, FN_LSR, FN_ASR, FN_ROL, FN_ROR, FN_DECADJ
  } crs_fn_t;
  typedef enum logic [1:0] {SEL_ACC, SEL_X, SEL_H, SEL_CCR} crs_sel_t;
  typedef enum logic [2:0] {EA_IX, EA_IX1, EA_IX2, EA_SP1, EA_SP2} crs_ea_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH, ST_PULL, ST_STACK, ST_VEC, ST_UNSTACK
  } crs_st_t;
  // Bits 6 and 5 always one
  function automatic logic [7:0] fix_ccr(input logic [7:0] v);
    return v | CCR_ONES;
  endfunction
endpackage

//--- hw/crs_flag_unit.sv
`timescale 1ns/1ns
module crs_flag_unit
  import crs_pkg::*;
(
  // Operation
  input crs_fn_t fn,
  input logic [7:0] a,
  input logic [7:0] m,
  input logic cin,
  input logic hin,
  // Result and flags
  output logic [7:0] res,
  output logic v,
  output logic h,
  output logic n,
  output logic z,
  output logic c,
  output logic upd_v,
  output logic upd_h,
  output logic upd_c
);
  logic cy_in;
  logic [8:0] sum;
  logic [8:0] dif;
  logic [4:0] lo_sum;
  logic [7:0] cor;
  logic [8:0] daa_sum;

  assign cy_in = (fn == FN_ADC || fn == FN_SBC) ? cin : 1'b0;
  assign sum = {1'b0, a} + {1'b0, m} + {8'h00, cy_in};
  assign dif = {1'b0, a} - {1'b0, m} - {8'h00, cy_in};
  assign lo_sum = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cy_in};
  assign cor[3:0] = (hin || a[3:0] > 4'h9) ? 4'h6 : 4'h0;
  assign cor[7:4] = (cin || a > 8'h99) ? 4'h6 : 4'h0;
  assign daa_sum = {1'b0, a} + {1'b0, cor};
  assign n = res[7];
  assign z = (res == 8'h00);

  always_comb begin
    res = a;
    v = 1'b0;
    h = 1'b0;
    c = 1'b0;
    upd_v = 1'b0;
    upd_h = 1'b0;
    upd_c = 1'b0;
    case (fn)
      FN_ADD, FN_ADC: begin
        res = sum[7:0];
        c = sum[8];
        h = lo_sum[4];
        v = (a[7] == m[7]) && (sum[7] != a[7]);
        upd_v = 1'b1;
        upd_h = 1'b1;
        upd_c = 1'b1;
      end
      FN_SUB, FN_SBC, FN_CMP: begin
        res = dif[7:0];
        c = dif[8];
        v = (a[7] != m[7]) && (dif[7] != a[7]);
        upd_v = 1'b1;
        upd_c = 1'b1;
      end
      FN_AND, FN_ORA, FN_EOR, FN_LDA: begin
        res = (fn == FN_AND) ? (a & m) : (fn == FN_ORA) ? (a | m) :
              (fn == FN_EOR) ? (a ^ m) : m;
        upd_v = 1'b1;
      end
      FN_LSL, FN_ROL, FN_LSR, FN_ASR, FN_ROR: begin
        res = (fn == FN_LSL) ? {a[6:0], 1'b0} : (fn == FN_ROL) ? {a[6:0], cin} :
              (fn == FN_LSR) ? {1'b0, a[7:1]} : (fn == FN_ASR) ? {a[7], a[7:1]} :
              {cin, a[7:1]};
        c = (fn == FN_LSL || fn == FN_ROL) ? a[7] : a[0];
        v = res[7] ^ c;
        upd_v = 1'b1;
        upd_c = 1'b1;
      end
      FN_DECADJ: begin
        res = daa_sum[7:0];
        c = cin | (cor[7:4] != 4'h0);
        upd_c = 1'b1;
      end
      default: begin
        res = a;
      end
    endcase
  end
endmodule

//--- hw/crs_core_regs.sv
`timescale 1ns/1ns
module crs_core_regs
  import crs_pkg::*;
#(
  parameter int N_IRQ = 4,
  parameter int AW = 8
) (
  // Clock and reset
  input logic ref_clk,
  input logic rst,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [AW-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer operations
  input logic op_valid,
  input crs_op_t op_code,
  input crs_fn_t op_fn,
  input crs_sel_t op_sel,
  input crs_ea_t op_ea,
  input logic [15:0] op_data,
  output logic busy,
  output logic op_done,
  output logic [15:0] ea_addr,
  // Memory bus master
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input logic mem_ack,
  input logic [7:0] mem_rdata,
  // Interrupt sources
  input logic [N_IRQ-1:0] irq_req,
  output logic [N_IRQ-1:0] irq_ack,
  // Register views
  output logic [7:0] acc,
  output logic [15:0] index_pair,
  output logic [15:0] stack_pointer,
  output logic [15:0] program_counter,
  output logic [7:0] condition_flags_register
);
  logic [7:0] acc_q, acc_d;
  logic [15:0] hx_q, hx_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] ccr_q, ccr_d;
  logic [15:0] ea_q, ea_d;
  crs_st_t st_q, st_d;
  logic [2:0] step_q, step_d;
  logic [15:0] vec_q, vec_d;
  crs_sel_t sel_q, sel_d;
  logic mreq_q, mreq_d, mwe_q, mwe_d;
  logic [15:0] maddr_q, maddr_d;
  logic [7:0] mwd_q, mwd_d;
  logic busy_q, pready_q, pslverr_q;
  logic done_q, done_d;
  logic [N_IRQ-1:0] iack_q, iack_d;
  logic [31:0] prdata_q;

  // Lowest index is the highest priority
  function automatic logic [15:0] pick_vec(input logic [N_IRQ-1:0] r);
    pick_vec = VEC_IRQ_TOP;
    for (int i = N_IRQ - 1; i >= 0; i--) begin
      if (r[i]) begin
        pick_vec = VEC_IRQ_TOP - 16'(2 * i);
      end
    end
  endfunction

  // Flag unit
  logic [7:0] f_res;
  logic f_v, f_h, f_n, f_z, f_c;
  logic f_uv, f_uh, f_uc;

  crs_flag_unit u_flags (
    .fn(op_fn),
    .a(acc_q),
    .m(op_data[7:0]),
    .cin(ccr_q[CCR_C]),
    .hin(ccr_q[CCR_H]),
    .res(f_res),
    .v(f_v),
    .h(f_h),
    .n(f_n),
    .z(f_z),
    .c(f_c),
    .upd_v(f_uv),
    .upd_h(f_uh),
    .upd_c(f_uc)
  );

  // Interrupt gating and selection
  logic [N_IRQ-1:0] irq_gate, irq_pick;
  assign irq_gate = irq_req & {N_IRQ{~ccr_q[CCR_I]}};
  assign irq_pick = irq_gate & (~irq_gate + N_IRQ'(1));

  // Effective address
  logic [15:0] ea_calc, off8;
  assign off8 = {8'h00, op_data[7:0]};
  assign ea_calc = (op_ea == EA_IX1) ? hx_q + off8 :
                   (op_ea == EA_IX2) ? hx_q + op_data :
                   (op_ea == EA_SP1) ? sp_q + off8 :
                   (op_ea == EA_SP2) ? sp_q + op_data : hx_q;

  // Memory access for the current state
  logic [15:0] up_addr, acc_addr;
  logic [7:0] stk_byte, sel_byte, acc_wd, pulled_ccr;
  logic acc_we;
  assign up_addr = sp_q + 16'h0001;
  // High index byte is not part of the frame
  assign stk_byte = (step_q == 3'h0) ? pc_q[7:0] :
                    (step_q == 3'h1) ? pc_q[15:8] :
                    (step_q == 3'h2) ? hx_q[7:0] :
                    (step_q == 3'h3) ? acc_q : ccr_q;
  assign sel_byte = (sel_q == SEL_ACC) ? acc_q : (sel_q == SEL_X) ? hx_q[7:0] :
                    (sel_q == SEL_H) ? hx_q[15:8] : ccr_q;
  assign acc_addr = (st_q == ST_STACK || st_q == ST_PUSH) ? sp_q :
                    (st_q == ST_VEC) ? vec_q + {13'h0000, step_q} : up_addr;
  assign acc_we = (st_q == ST_STACK || st_q == ST_PUSH);
  assign acc_wd = (st_q == ST_STACK) ? stk_byte : sel_byte;
  assign pulled_ccr = fix_ccr(mem_rdata | (ccr_q & (8'h01 << CCR_I)));

  // APB decode
  logic setup, wr_go, hit, rd_err, wr_err;
  logic [7:0] addr8, wr_ccr;
  logic [31:0] rd_stat, rd_mux;
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign addr8 = paddr[7:0];
  assign hit = (addr8 == OFF_ACC) || (addr8 == OFF_HX) || (addr8 == OFF_SP) ||
               (addr8 == OFF_PC) || (addr8 == OFF_CCR) || (addr8 == OFF_STAT);
  assign rd_err = ~hit;
  assign wr_err = ~hit || (addr8 == OFF_STAT) || busy_q;
  assign rd_stat = {31'h00000000, busy_q} | (32'(irq_gate) << STAT_PEND_LSB);
  assign rd_mux = (addr8 == OFF_ACC) ? {24'h000000, acc_q} :
                  (addr8 == OFF_HX) ? {16'h0000, hx_q} :
                  (addr8 == OFF_SP) ? {16'h0000, sp_q} :
                  (addr8 == OFF_PC) ? {16'h0000, pc_q} :
                  (addr8 == OFF_CCR) ? {24'h000000, ccr_q} :
                  (addr8 == OFF_STAT) ? rd_stat : 32'h00000000;
  // Software may set the mask here but never clear it
  assign wr_ccr = fix_ccr(pwdata[7:0] | (ccr_q & (8'h01 << CCR_I)));

  always_comb begin
    acc_d = acc_q;
    hx_d = hx_q;
    sp_d = sp_q;
    pc_d = pc_q;
    ccr_d = ccr_q;
    ea_d = ea_q;
    st_d = st_q;
    step_d = step_q;
    vec_d = vec_q;
    sel_d = sel_q;
    mreq_d = mreq_q;
    mwe_d = mwe_q;
    maddr_d = maddr_q;
    mwd_d = mwd_q;
    done_d = 1'b0;
    iack_d = '0;
    case (st_q)
      ST_IDLE: begin
        if (op_valid) begin
          done_d = 1'b1;
          sel_d = op_sel;
          case (op_code)
            OP_FETCH: pc_d = pc_q + 16'h0001;
            OP_JUMP: pc_d = op_data;
            OP_ALU: begin
              acc_d = (op_fn == FN_CMP) ? acc_q : f_res;
              ccr_d[CCR_N] = f_n;
              ccr_d[CCR_Z] = f_z;
              ccr_d[CCR_V] = f_uv ? f_v : ccr_q[CCR_V];
              ccr_d[CCR_H] = f_uh ? f_h : ccr_q[CCR_H];
              ccr_d[CCR_C] = f_uc ? f_c : ccr_q[CCR_C];
            end
            OP_LDH: hx_d[15:8] = op_data[7:0];
            OP_LDX: hx_d[7:0] = op_data[7:0];
            OP_LDSP: sp_d = op_data;
            OP_SPLOW: sp_d[7:0] = SP_LOW_RST;
            OP_PUSH: begin
              st_d = ST_PUSH;
              done_d = 1'b0;
            end
            OP_PULL: begin
              st_d = ST_PULL;
              done_d = 1'b0;
            end
            OP_EA: ea_d = ea_calc;
            OP_UNMASK: ccr_d[CCR_I] = 1'b0;
            OP_SEI: ccr_d[CCR_I] = 1'b1;
            OP_INTCHK: begin
              if (|irq_gate) begin
                st_d = ST_STACK;
                step_d = 3'h0;
                vec_d = pick_vec(irq_gate);
                iack_d = irq_pick;
                done_d = 1'b0;
              end
            end
            OP_IRQRET: begin
              st_d = ST_UNSTACK;
              step_d = 3'h0;
              done_d = 1'b0;
            end
            default: done_d = 1'b1;
          endcase
        end
      end
      default: begin
        if (!mreq_q) begin
          mreq_d = 1'b1;
          maddr_d = acc_addr;
          mwe_d = acc_we;
          mwd_d = acc_wd;
        end else if (mem_ack) begin
          mreq_d = 1'b0;
          mwe_d = 1'b0;
          step_d = step_q + 3'h1;
          case (st_q)
            ST_PUSH: begin
              sp_d = sp_q - 16'h0001;
              st_d = ST_IDLE;
              done_d = 1'b1;
            end
            ST_PULL: begin
              sp_d = up_addr;
              st_d = ST_IDLE;
              done_d = 1'b1;
              case (sel_q)
                SEL_ACC: acc_d = mem_rdata;
                SEL_X: hx_d[7:0] = mem_rdata;
                SEL_H: hx_d[15:8] = mem_rdata;
                default: ccr_d = pulled_ccr;
              endcase
            end
            ST_STACK: begin
              sp_d = sp_q - 16'h0001;
              if (step_q == STACK_LAST) begin
                ccr_d[CCR_I] = 1'b1;
                st_d = ST_VEC;
                step_d = 3'h0;
              end
            end
            ST_VEC: begin
              if (step_q == 3'h0) begin
                pc_d[15:8] = mem_rdata;
              end else begin
                pc_d[7:0] = mem_rdata;
                st_d = ST_IDLE;
                done_d = (vec_q != VEC_RESET);
              end
            end
            ST_UNSTACK: begin
              sp_d = up_addr;
              case (step_q)
                3'h0: ccr_d = fix_ccr(mem_rdata);
                3'h1: acc_d = mem_rdata;
                3'h2: hx_d[7:0] = mem_rdata;
                3'h3: pc_d[15:8] = mem_rdata;
                default: begin
                  pc_d[7:0] = mem_rdata;
                  st_d = ST_IDLE;
                  done_d = 1'b1;
                end
              endcase
            end
            default: st_d = ST_IDLE;
          endcase
        end
      end
    endcase
    if (wr_go) begin
      case (addr8)
        OFF_ACC: acc_d = pwdata[7:0];
        OFF_HX: hx_d = pwdata[15:0];
        OFF_SP: sp_d = pwdata[15:0];
        OFF_PC: pc_d = pwdata[15:0];
        OFF_CCR: ccr_d = wr_ccr;
        default: acc_d = acc_d;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_q <= 8'h00;
      hx_q <= 16'h0000;
      sp_q <= SP_RST;
      pc_q <= 16'h0000;
      ccr_q <= CCR_RST;
      ea_q <= 16'h0000;
      st_q <= ST_VEC;
      step_q <= 3'h0;
      vec_q <= VEC_RESET;
      sel_q <= SEL_ACC;
    end else begin
      acc_q <= acc_d;
      hx_q <= hx_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      ccr_q <= fix_ccr(ccr_d);
      ea_q <= ea_d;
      st_q <= st_d;
      step_q <= step_d;
      vec_q <= vec_d;
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mreq_q <= 1'b0;
      mwe_q <= 1'b0;
      maddr_q <= 16'h0000;
      mwd_q <= 8'h00;
      busy_q <= 1'b1;
      done_q <= 1'b0;
      iack_q <= '0;
    end else begin
      mreq_q <= mreq_d;
      mwe_q <= mwe_d;
      maddr_q <= maddr_d;
      mwd_q <= mwd_d;
      busy_q <= (st_d != ST_IDLE);
      done_q <= done_d;
      iack_q <= iack_d;
    end
  end

  // Zero-wait APB answer in the access phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & (pwrite ? wr_err : rd_err);
      prdata_q <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign busy = busy_q;
  assign op_done = done_q;
  assign ea_addr = ea_q;
  assign mem_req = mreq_q;
  assign mem_we = mwe_q;
  assign mem_addr = maddr_q;
  assign mem_wdata = mwd_q;
  assign irq_ack = iack_q;
  assign acc = acc_q;
  assign index_pair = hx_q;
  assign stack_pointer = sp_q;
  assign program_counter = pc_q;
  assign condition_flags_register = ccr_q;
endmodule

//--- verif/crs_assertions.sv
`timescale 1ns/1ns
module crs_assertions
  import crs_pkg::*;
#(
  parameter int N_IRQ = 4,
  parameter int AW = 8
) (
  // Clock and reset
  input logic ref_clk,
  input logic rst,
  // Sequencer
  input logic op_valid,
  input crs_op_t op_code,
  input logic busy,
  // Memory and interrupts
  input logic mem_req,
  input logic mem_we,
  input logic mem_ack,
  input logic [15:0] mem_addr,
  input logic [N_IRQ-1:0] irq_req,
  input logic [N_IRQ-1:0] irq_ack,
  // Register views
  input logic [15:0] stack_pointer,
  input logic [7:0] condition_flags_register
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic boot_q;
  logic entry_q;
  logic [2:0] wcnt_q;
  sequence wr_ack_s;
    mem_req && mem_ack && mem_we;
  endsequence
  sequence rd_ack_s;
    mem_req && mem_ack && !mem_we;
  endsequence
  // Follows the boot fetch and the stacking phase of interrupt entry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boot_q <= 1'b1;
      entry_q <= 1'b0;
      wcnt_q <= 3'h0;
    end else begin
      if (mem_req && mem_ack) boot_q <= 1'b0;
      if (irq_ack != '0) begin
        entry_q <= 1'b1;
        wcnt_q <= 3'h0;
      end else if (mem_req && mem_ack && !mem_we) begin
        entry_q <= 1'b0;
      end else if (entry_q && mem_req && mem_ack) begin
        wcnt_q <= wcnt_q + 3'h1;
      end
    end
  end
  ccr_ones_a: assert property (condition_flags_register[6:5] == 2'b11)
    else $error("ccr bits 6 and 5 not one");
  mask_clear_a: assert property ($fell(condition_flags_register[3]) |->
    $past(busy) || $past(op_valid && op_code == OP_UNMASK))
    else $error("mask cleared without clear-mask");
  stack_low_a: assert property (op_valid && !busy && op_code == OP_SPLOW |=>
    stack_pointer == {$past(stack_pointer[15:8]), 8'hFF})
    else $error("stack reset wrong");
  push_dec_a: assert property (wr_ack_s |=>
    stack_pointer == $past(stack_pointer) - 16'h1)
    else $error("push did not decrement");
  irq_prio_a: assert property (irq_ack != '0 |->
    irq_ack == ($past(irq_req) & (~$past(irq_req) + 1'b1)))
    else $error("wrong interrupt accepted");
  mask_blocks_a: assert property (irq_ack != '0 |-> !$past(condition_flags_register[3]))
    else $error("interrupt taken while masked");
  frame_len_a: assert property (entry_q ##0 rd_ack_s |-> wcnt_q == 3'h5)
    else $error("frame not five bytes");
  stack_unmasked_a: assert property (entry_q ##0 wr_ack_s |->
    !condition_flags_register[3])
    else $error("mask set before stacking done");
  vec_masked_a: assert property (entry_q && mem_req && !mem_we |->
    condition_flags_register[3])
    else $error("vector fetched unmasked");
  boot_vec_a: assert property (boot_q && mem_req |-> mem_addr == VEC_RESET && !mem_we)
    else $error("boot fetch not at vector");
endmodule

//--- verif/crs_mem_model.sv
`timescale 1ns/1ns
module crs_mem_model (
  // Clock and reset
  input logic ref_clk,
  input logic rst,
  // Memory bus
  input logic mem_req,
  input logic mem_we,
  input logic [15:0] mem_addr,
  input logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // Wait states before each answer
  input logic [3:0] dly
);
  logic [7:0] m [0:65535];
  logic [3:0] cnt_q;
  initial begin
    foreach (m[i]) m[i] = 8'h00;
    m[16'hFFFE] = 8'h12;
    m[16'hFFFF] = 8'h34;
    m[16'hFFFA] = 8'h56;
    m[16'hFFFB] = 8'h78;
  end
  // Read data is only valid with ack; otherwise it toggles
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      cnt_q <= 4'h0;
    end else if (mem_req && !mem_ack && cnt_q == dly) begin
      mem_ack <= 1'b1;
      cnt_q <= 4'h0;
      mem_rdata <= m[mem_addr];
      if (mem_we) m[mem_addr] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ns
module testbench
  import crs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic op_valid = 1'b0;
  crs_op_t op_code = OP_NOP;
  crs_fn_t op_fn = FN_ADD;
  crs_sel_t op_sel = SEL_ACC;
  crs_ea_t op_ea = EA_IX;
  logic [15:0] op_data = 16'h0;
  logic busy, op_done, mem_req, mem_we, mem_ack;
  logic [15:0] ea_addr, mem_addr, index_pair, stack_pointer, program_counter;
  logic [7:0] mem_wdata, mem_rdata, acc, condition_flags_register;
  logic [3:0] irq_req = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [3:0] irq_ack;
  logic [3:0] ack_seen = 4'h0;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  // fn, acc in, operand, ccr in, acc out, ccr out
  localparam logic [43:0] T [8] = '{
    {FN_ADD, 8'h08, 8'h08, 8'h00, 8'h10, 8'h78}, {FN_ADD, 8'h7F, 8'h01, 8'h00, 8'h80, 8'hFC},
    {FN_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h7B}, {FN_ADC, 8'h01, 8'h01, 8'h01, 8'h03, 8'h68},
    {FN_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h6D}, {FN_DECADJ, 8'h12, 8'h00, 8'h10, 8'h18, 8'h78},
    {FN_LSR, 8'h01, 8'h00, 8'h00, 8'h00, 8'hEB}, {FN_AND, 8'hF0, 8'h0F, 8'h80, 8'h00, 8'h6A}};
  localparam logic [34:0] E [5] = '{{EA_SP1, 16'h0010, 16'h0090},
    {EA_SP2, 16'h0100, 16'h0180}, {EA_IX, 16'h0000, 16'h3C5A},
    {EA_IX1, 16'h00F0, 16'h3D4A}, {EA_IX2, 16'h0100, 16'h3D5A}};
  localparam logic [39:0] F = 40'h00205AA560;
  crs_core_regs dut (.*);
  crs_mem_model mem (.*);
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (irq_ack !== 4'h0) ack_seen <= irq_ack;
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input crs_op_t c, input crs_fn_t f, input crs_sel_t s, input crs_ea_t e,
                    input logic [15:0] d);
    @(posedge ref_clk);
    while (busy !== 1'b0) @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_fn <= f;
    op_sel <= s;
    op_ea <= e;
    op_data <= d;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    do @(posedge ref_clk); while (op_done !== 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    chk("sp reset", stack_pointer, SP_RST);
    chk("ccr reset", condition_flags_register, CCR_RST);
    rst <= 1'b0;
    op(OP_NOP, FN_ADD, SEL_ACC, EA_IX, 16'h0);
    chk("pc vector", program_counter, 16'h1234);
    apb(1'b1, OFF_CCR, 32'h0);
    apb(1'b0, OFF_CCR, 32'h0);
    chk("ccr read", rd, 32'h68);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", err, 1'b1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFF_ACC, {24'h0, T[i][39:32]});
      apb(1'b1, OFF_CCR, {24'h0, T[i][23:16]});
      op(OP_ALU, crs_fn_t'(T[i][43:40]), SEL_ACC, EA_IX, {8'h00, T[i][31:24]});
      chk("alu acc", acc, T[i][15:8]);
      chk("alu ccr", condition_flags_register, T[i][7:0]);
    end
    apb(1'b1, OFF_SP, 32'h1234);
    op(OP_SPLOW, FN_ADD, SEL_ACC, EA_IX, 16'h0);
    chk("stack reset", stack_pointer, 16'h12FF);
    apb(1'b1, OFF_SP, 32'h0080);
    apb(1'b1, OFF_HX, 32'h3C5A);
    apb(1'b1, OFF_ACC, 32'hA5);
    dly <= 4'h2;
    op(OP_PUSH, FN_ADD, SEL_H, EA_IX, 16'h0);
    chk("push mem", mem.m[16'h0080], 8'h3C);
    chk("push sp", stack_pointer, 16'h007F);
    apb(1'b1, OFF_HX, 32'h005A);
    op(OP_PULL, FN_ADD, SEL_H, EA_IX, 16'h0);
    chk("pull hx", index_pair, 16'h3C5A);
    chk("pull sp", stack_pointer, 16'h0080);
    for (int i = 0; i < 5; i++) begin
      op(OP_EA, FN_ADD, SEL_ACC, crs_ea_t'(E[i][34:32]), E[i][31:16]);
      chk("ea", ea_addr, E[i][15:0]);
    end
    op(OP_JUMP, FN_ADD, SEL_ACC, EA_IX, 16'h1FFF);
    op(OP_FETCH, FN_ADD, SEL_ACC, EA_IX, 16'h0);
    chk("pc step", program_counter, 16'h2000);
    apb(1'b1, OFF_CCR, 32'h0);
    irq_req <= 4'h6;
    op(OP_INTCHK, FN_ADD, SEL_ACC, EA_IX, 16'h0);
    chk("masked ack", ack_seen, 4'h0);
    chk("masked sp", stack_pointer, 16'h0080);
    op(OP_UNMASK, FN_ADD, SEL_ACC, EA_IX, 16'h0);
    chk("unmask", condition_flags_register, 8'h60);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("pending", rd, 32'h600);
    op(OP_INTCHK, FN_ADD, SEL_ACC, EA_IX, 16'h0);
    irq_req <= 4'h0;
    chk("ack", ack_seen, 4'h2);
    for (int i = 0; i < 5; i++) begin
      chk("frame", mem.m[16'h0080 - i], F[39-8*i -: 8]);
    end
    chk("no high", mem.m[16'h007B], 8'h00);
    chk("entry sp", stack_pointer, 16'h007B);
    chk("entry pc", program_counter, 16'h5678);
    chk("entry mask", condition_flags_register, 8'h68);
    apb(1'b1, OFF_ACC, 32'h0);
    op(OP_IRQRET, FN_ADD, SEL_ACC, EA_IX, 16'h0);
    chk("ret acc", acc, 8'hA5);
    chk("ret pc", program_counter, 16'h2000);
    chk("ret sp", stack_pointer, 16'h0080);
    chk("ret ccr", condition_flags_register, 8'h60);
    report_and_stop();
  end
endmodule
bind crs_core_regs crs_assertions #(.N_IRQ(N_IRQ), .AW(AW)) asrt (.*);
